// File: logic/sdc_pkg.sv
package sdc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_TX  = 8'h29;  // Transmit buffer, write only
  localparam logic [7:0] IDX_RX  = 8'h2a;  // Receive buffer, read only
  localparam logic [7:0] IDX_CR  = 8'h2b;  // Control and status
  localparam logic [7:0] IDX_CFG = 8'h2c;  // Configuration

  // ************************************************************
  // Control/status field positions
  // ************************************************************
  localparam int CR_LSB  = 7;  // Bit order select
  localparam int CR_OVR  = 6;  // Overrun status
  localparam int CR_CMP  = 5;  // Transfer complete status
  localparam int CR_TXE  = 4;  // Transmit buffer empty status
  localparam int CR_RXF  = 3;  // Receive buffer full status
  localparam int CR_CPHA = 2;  // Clock phase
  localparam int CR_CPOL = 1;  // Clock polarity
  localparam int CR_EN   = 0;  // Block enable

  // ************************************************************
  // Reset values and constants
  // ************************************************************
  localparam logic [7:0] RX_RST  = 8'h00;  // Receive buffer reset
  localparam logic [7:0] CR_RST  = 8'h00;  // Control reset
  localparam logic [7:0] CFG_RST = 8'h00;  // Configuration reset
  localparam logic [7:0] TX_RST  = 8'h00;  // Transmit buffer reset
  localparam logic [2:0] BIT_LAST  = 3'h7;  // Eighth sample index
  localparam logic [3:0] EDGE_LAST = 4'hf;  // Sixteenth half period

  // ************************************************************
  // Carriers
  // ************************************************************
  // Writable control bits
  typedef struct packed {
    logic lsb_first;  // Least significant bit first
    logic cpha;       // Clock phase
    logic cpol;       // Clock polarity
    logic en;         // Block enable
  } sdc_ctrl_t;

  // Configuration byte layout
  typedef struct packed {
    logic [2:0] clk_sel;  // Master half period is 2**clk_sel cycles
    logic       bypass;   // Stored only, inputs are always synchronised
    logic       ss_bit;   // Internal select level
    logic       ss_en_n;  // Low selects by the internal bit
    logic       int_sel;  // Stored only
    logic       slave;    // Slave role
  } sdc_cfg_t;

  // Master sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } sdc_state_t;

endpackage : sdc_pkg

// File: logic/sdc_sync.sv
// Two-stage synchroniser, one per input bit
module sdc_sync #(
  parameter int W = 4  // Number of bits
) (
  // Clock and control
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ************************************************************
  // Synchroniser chains
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;  // First stage, read only by the second

      // Two flops in series per bit
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          meta_q <= 1'b0;
          q[i]   <= 1'b0;
        end
        else if (ce)
        begin
          meta_q <= d[i];
          q[i]   <= meta_q;
        end
      end
    end
  endgenerate

endmodule : sdc_sync

// File: logic/sdc_spi.sv
// Contract
// - Receive buffer: read only, resets zero, last byte
// - Writing receive buffer address clears receive full
// - Master idle write loads shifter, starts transfer
// - Busy master holds written byte as queued
// - Transfer to shifter sets transmit empty
// - Transmit empty bit four, write clears
// - Completed byte copied to buffer, full set
// - Receive full bit three, buffer read clears
// - Control register eight bits, mixed access, zero
// - Bit seven selects least significant first
// - Overrun set when unread byte overwritten
// - Complete flag bit five, register read clears
// - Bit two selects clock phase
// - Bit one selects clock idle level
// - Bit zero enables serial function
// - Transmit empty asserted at once on enable
// - Disable idles outputs, resets state and status; master out keeps shifter bit 7
// - Receive full set on eighth sample edge
//
// Implementation choice: the Wishbone slave port.
module sdc_spi (
  // Clock and control
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  // Wishbone slave
  input  wire logic       wb_cyc,
  input  wire logic       wb_stb,
  input  wire logic       wb_we,
  input  wire logic [9:0] wb_adr,
  input  wire logic [3:0] wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic            wb_ack,
  // Serial clock pin
  input  wire logic       sclk_i,
  output logic            sclk_o,
  output logic            sclk_oe_n,
  // Master out pin
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe_n,
  // Slave out pin
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe_n,
  // Slave select input
  input  wire logic       ss_n_i
);

  // ************************************************************
  // Declarations
  // ************************************************************
  sdc_pkg::sdc_ctrl_t  ctrl_q;        // Writable control bits
  sdc_pkg::sdc_cfg_t   cfg_q;         // Configuration byte
  sdc_pkg::sdc_state_t state_q;       // Master sequencer
  logic [7:0] tx_q;                   // Transmit holding register
  logic [7:0] rx_q;                   // Receive buffer
  logic [7:0] sh_q;                   // Output shifter, bit 7 on pin
  logic [7:0] rsh_q;                  // Input shifter
  logic [7:0] tx_ord;                 // Transmit byte in pin order
  logic [7:0] rx_raw;                 // Completed input byte
  logic [7:0] rx_ord;                 // Completed byte in bus order
  logic [7:0] div_q;                  // Half period counter
  logic [7:0] half_m1;                // Half period minus one
  logic [3:0] edge_q;                 // Master edge index
  logic [2:0] bit_q;                  // Samples taken this byte
  logic       txe_q, rxf_q, cmp_q, ovr_q;  // Status flags
  logic       busy_q, busy_d;         // Shifter holds a byte
  logic       skip_q;                 // Next shift edge is ignored
  logic       end_q;                  // Byte ended last cycle, chain slot
  logic       sclk_q;                 // Master clock level
  logic       sclk_s, mosi_s, miso_s, ss_n_s;  // Synchronised pins
  logic       sclk_p_q;               // Previous synchronised clock
  logic       sel_q;                  // Slave selected, registered
  logic       acc, rd, wr;            // Bus access this cycle
  logic       wr_tx, wr_rx, rd_rx, rd_cr;  // Register side effects
  logic       en, slv, sel;           // Mode terms
  logic       tick, lead, trail;      // Clock events
  logic       sample_ev, shift_ev;    // Data events
  logic       last_sample, idle_load, chain_load, load;
  logic       din;                    // Incoming data bit

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  sdc_sync #(.W(4)) u_sync (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .d     ({sclk_i, mosi_i, miso_i, ss_n_i}),
    .q     ({sclk_s, mosi_s, miso_s, ss_n_s})
  );

  // ************************************************************
  // Wishbone decode
  // ************************************************************
  assign acc   = wb_cyc & wb_stb & ~wb_ack;          // One access per request
  assign rd    = acc & ~wb_we;
  assign wr    = acc & wb_we & wb_sel[0];            // Low lane carries data
  assign wr_tx = wr & (wb_adr[9:2] == sdc_pkg::IDX_TX);
  assign wr_rx = wr & (wb_adr[9:2] == sdc_pkg::IDX_RX);
  assign rd_rx = rd & (wb_adr[9:2] == sdc_pkg::IDX_RX);
  assign rd_cr = rd & (wb_adr[9:2] == sdc_pkg::IDX_CR);

  // Ack and read data, one cycle after the request
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack   <= acc;
      wb_dat_r <= 32'h0000_0000;
      if (rd)
      begin
        case (wb_adr[9:2])
          sdc_pkg::IDX_RX:  wb_dat_r[7:0] <= rx_q;
          sdc_pkg::IDX_CR:  wb_dat_r[7:0] <= {ctrl_q.lsb_first, ovr_q, cmp_q,
                                              txe_q & en, rxf_q, ctrl_q.cpha,
                                              ctrl_q.cpol, ctrl_q.en};
          sdc_pkg::IDX_CFG: wb_dat_r[7:0] <= cfg_q;
          default:          wb_dat_r[7:0] <= 8'h00;  // Unmapped or write only
        endcase
      end
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  // Control bits; status bits of the byte are not writable
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_q <= sdc_ctrl_reset();
    else if (ce && wr && wb_adr[9:2] == sdc_pkg::IDX_CR)
      ctrl_q <= {wb_dat_w[sdc_pkg::CR_LSB], wb_dat_w[sdc_pkg::CR_CPHA],
                 wb_dat_w[sdc_pkg::CR_CPOL], wb_dat_w[sdc_pkg::CR_EN]};
  end

  // Configuration; software leaves it alone while enabled
  always_ff @(posedge clock)
  begin
    if (rst)
      cfg_q <= sdc_pkg::CFG_RST;
    else if (ce && wr && wb_adr[9:2] == sdc_pkg::IDX_CFG)
      cfg_q <= wb_dat_w[7:0];
  end

  // Transmit holding register, queues while busy
  always_ff @(posedge clock)
  begin
    if (rst)
      tx_q <= sdc_pkg::TX_RST;
    else if (ce && wr_tx)
      tx_q <= wb_dat_w[7:0];
  end

  // Reset value of the control bits from the byte layout
  function automatic sdc_pkg::sdc_ctrl_t sdc_ctrl_reset();
    sdc_ctrl_reset = {sdc_pkg::CR_RST[sdc_pkg::CR_LSB], sdc_pkg::CR_RST[sdc_pkg::CR_CPHA],
                      sdc_pkg::CR_RST[sdc_pkg::CR_CPOL], sdc_pkg::CR_RST[sdc_pkg::CR_EN]};
  endfunction : sdc_ctrl_reset

  // ************************************************************
  // Bit order
  // ************************************************************
  assign rx_raw = {rsh_q[6:0], din};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rev
      // Pin order is bit 7 first; reverse only for least significant first
      assign tx_ord[gi] = ctrl_q.lsb_first ? tx_q[7-gi] : tx_q[gi];
      assign rx_ord[gi] = ctrl_q.lsb_first ? rx_raw[7-gi] : rx_raw[gi];
    end
  endgenerate

  // ************************************************************
  // Clock events
  // ************************************************************
  assign en      = ctrl_q.en;
  assign slv     = cfg_q.slave;
  assign sel     = cfg_q.ss_en_n ? ~ss_n_s : ~cfg_q.ss_bit;
  assign half_m1 = (8'h01 << cfg_q.clk_sel) - 8'h01;
  assign tick    = en & ~slv & (state_q == sdc_pkg::ST_RUN) & (div_q == half_m1);
  assign lead    = slv ? (en & sel & (sclk_s != sclk_p_q) & (sclk_s != ctrl_q.cpol))
                       : (tick & ~edge_q[0]);
  assign trail   = slv ? (en & sel & (sclk_s != sclk_p_q) & (sclk_s == ctrl_q.cpol))
                       : (tick & edge_q[0]);
  assign sample_ev = ctrl_q.cpha ? trail : lead;
  assign shift_ev  = ctrl_q.cpha ? lead : trail;
  assign din       = slv ? mosi_s : miso_s;
  assign last_sample = sample_ev & (bit_q == sdc_pkg::BIT_LAST);
  // Shifter loads: from idle, or back to back one cycle after a byte end,
  // so the data pin never moves on the edge where the far side samples
  assign idle_load  = en & ~txe_q & ~busy_q &
                      (slv | (state_q == sdc_pkg::ST_IDLE));
  assign chain_load = en & end_q & ~txe_q;
  assign load       = idle_load | chain_load;
  // A queued byte at the byte end keeps the shifter busy for the chain slot
  assign busy_d     = load ? 1'b1 : ((last_sample && txe_q) ? 1'b0 : busy_q);

  // ************************************************************
  // Master sequencer
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= sdc_pkg::ST_IDLE;
      div_q   <= 8'h00;
      edge_q  <= 4'h0;
      sclk_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (!en || slv)
      begin
        // Idle level follows polarity
        state_q <= sdc_pkg::ST_IDLE;
        div_q   <= 8'h00;
        edge_q  <= 4'h0;
        sclk_q  <= ctrl_q.cpol;
      end
      else
      begin
        case (state_q)
          sdc_pkg::ST_IDLE:
          begin
            sclk_q <= ctrl_q.cpol;
            if (idle_load)
            begin
              state_q <= sdc_pkg::ST_RUN;
              div_q   <= 8'h00;
              edge_q  <= 4'h0;
            end
          end
          sdc_pkg::ST_RUN:
          begin
            if (tick)
            begin
              div_q  <= 8'h00;
              edge_q <= edge_q + 4'h1;
              sclk_q <= ~sclk_q;
              if (edge_q == sdc_pkg::EDGE_LAST && !busy_d)
                state_q <= sdc_pkg::ST_IDLE;
            end
            else
              div_q <= div_q + 8'h01;
          end
          default: state_q <= sdc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // Shifters and byte framing
  // ************************************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sh_q     <= sdc_pkg::TX_RST;
      rsh_q    <= sdc_pkg::RX_RST;
      bit_q    <= 3'h0;
      busy_q   <= 1'b0;
      skip_q   <= 1'b0;
      end_q    <= 1'b0;
      sclk_p_q <= 1'b0;
      sel_q    <= 1'b0;
    end
    else if (ce)
    begin
      sclk_p_q <= sclk_s;
      sel_q    <= en & slv & sel;
      if (!en || (slv && !sel))
      begin
        // Framing reset; shifter kept, a queued byte still loads
        bit_q  <= 3'h0;
        busy_q <= en & busy_d;
        skip_q <= load ? ctrl_q.cpha : (en & skip_q);
        end_q  <= 1'b0;
        if (load)
          sh_q <= tx_ord;
      end
      else
      begin
        busy_q <= busy_d;
        end_q  <= last_sample;
        if (sample_ev)
        begin
          rsh_q <= rx_raw;
          bit_q <= bit_q + 3'h1;
        end
        if (load)
        begin
          sh_q   <= tx_ord;
          // A load on a shift edge takes that edge's place
          skip_q <= (ctrl_q.cpha | chain_load) & ~shift_ev;
        end
        else if (shift_ev)
        begin
          if (skip_q)
            skip_q <= 1'b0;
          else
            sh_q <= {sh_q[6:0], 1'b1};
        end
      end
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  // Transmit empty; forced set while disabled so enable shows it
  always_ff @(posedge clock)
  begin
    if (rst)
      txe_q <= 1'b1;
    else if (ce)
    begin
      if (!en)
        txe_q <= 1'b1;
      else if (load)
        txe_q <= 1'b1;
      else if (wr_tx)
        txe_q <= 1'b0;
    end
  end

  // Receive buffer, full, overrun and complete; set beats clear
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_q  <= sdc_pkg::RX_RST;
      rxf_q <= 1'b0;
      ovr_q <= 1'b0;
      cmp_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!en)
      begin
        rxf_q <= 1'b0;
        ovr_q <= 1'b0;
        cmp_q <= 1'b0;
      end
      else if (last_sample)
      begin
        rx_q  <= rx_ord;
        rxf_q <= 1'b1;
        ovr_q <= ovr_q | (rxf_q & ~rd_rx);
        cmp_q <= 1'b1;
      end
      else
      begin
        if (rd_rx || wr_rx)
          rxf_q <= 1'b0;
        if (rd_rx)
          ovr_q <= 1'b0;
        if (rd_cr)
          cmp_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Pins
  // ************************************************************
  assign sclk_o    = sclk_q;
  assign sclk_oe_n = slv;
  assign mosi_o    = sh_q[7];
  assign mosi_oe_n = slv;
  assign miso_o    = sh_q[7] | ~sel_q;  // Idles high when not selected
  assign miso_oe_n = ~slv;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !ce);

  a_load_sets_txe:  assert property (load |=> txe_q)
    else $error("Transmit empty not set after load");
  a_write_clr_txe:  assert property (wr_tx && en && !load |=> !txe_q)
    else $error("Transmit empty not cleared by write");
  a_start_load:     assert property (idle_load && !slv |=> state_q == sdc_pkg::ST_RUN
                                     && sh_q == $past(tx_ord))
    else $error("Master did not start with the written byte");
  a_rx_capture:     assert property (last_sample && en |=> rxf_q && cmp_q
                                     && rx_q == $past(rx_ord))
    else $error("Eighth sample did not capture the byte");
  a_rx_read_clear:  assert property (rd_rx && !last_sample && en |=> !rxf_q)
    else $error("Receive full not cleared by read");
  a_overrun_set:    assert property (last_sample && en && rxf_q && !rd_rx |=> ovr_q)
    else $error("Overrun not flagged");
  a_cmp_read_clr:   assert property (rd_cr && !last_sample |=> !cmp_q)
    else $error("Complete flag not cleared by read");
  a_enable_txe:     assert property ($rose(ctrl_q.en) |-> txe_q)
    else $error("Transmit empty not set on enable");
  a_disable_idle:   assert property (!en ##1 !en |-> sclk_o == ctrl_q.cpol
                                     && !rxf_q && !cmp_q && bit_q == 3'h0)
    else $error("Disabled block not idle");

  c_master_done:  cover property (!slv && last_sample);
  c_chained:      cover property (chain_load);
  c_overrun:      cover property (last_sample && rxf_q);
  c_slave_byte:   cover property (slv && last_sample);

endmodule : sdc_spi

// File: tb/sdc_spi_slave_model.sv
// Behavioural far-side device for the master role
module sdc_spi_slave_model (
  // Serial wires
  input  wire logic       active,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  // Mode and data
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  int k;  // Bit index, runs on across bytes

  // Outgoing bit in the chosen order
  function automatic logic pick(input int i);
    return lsb_first ? tx_byte[i % 8] : tx_byte[7 - i % 8];
  endfunction : pick

  // Idle level before the first frame
  initial
  begin
    miso    = 1'h1;
    rx_byte = 8'h00;
    k       = 0;
  end

  // Frame start shows bit one in phase 0 and inverts the pin in phase 1, frame end drops to the inverse
  always @(active)
  begin
    k = 0;
    if (active)
      miso = cpha ? ~miso : pick(0);
    else
      miso = ~miso;
  end

  // Leading edge away from idle, sample or change per phase
  always @(sclk)
  begin
    if (active)
    begin
      if ((sclk != cpol) != cpha)
        rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      else if (cpha)
      begin
        miso = pick(k);
        k++;
      end
      else
      begin
        k++;
        miso = pick(k);
      end
    end
  end
endmodule : sdc_spi_slave_model

// File: tb/sdc_spi_tb.sv
module sdc_spi_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Signals
  // ****************
  logic        clock, rst, ce, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [9:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic        sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_n_i;
  logic        tb_sclk, tb_mosi, act, p_cpol, p_cpha, p_lsb, p_miso;
  logic [7:0]  p_tx, p_rx, r, q;
  int          n_errors, cmp_count;
  // Wire levels from whoever drives
  wire logic   sclk_w = sclk_oe_n ? tb_sclk : sclk_o;
  wire logic   mosi_w = mosi_oe_n ? tb_mosi : mosi_o;
  wire logic   miso_w = miso_oe_n ? p_miso : miso_o;

  // Register case: write flag, byte enables, index, data, read value
  typedef struct {logic we; logic [3:0] sel; logic [7:0] idx, wd, exp;} sdc_row_t;
  sdc_row_t rows [12] = '{
    '{0, 4'hf, 8'h2b, 8'h00, 8'h00}, '{0, 4'hf, 8'h2a, 8'h00, 8'h00},
    '{1, 4'hf, 8'h2b, 8'hff, 8'h00}, '{0, 4'hf, 8'h2b, 8'h00, 8'h97},
    '{1, 4'he, 8'h2b, 8'h00, 8'h00}, '{0, 4'hf, 8'h2b, 8'h00, 8'h97},
    '{1, 4'hf, 8'h2a, 8'h55, 8'h00}, '{0, 4'hf, 8'h2a, 8'h00, 8'h00},
    '{0, 4'hf, 8'h29, 8'h00, 8'h00}, '{0, 4'hf, 8'h30, 8'h00, 8'h00},
    '{1, 4'hf, 8'h2b, 8'h00, 8'h00}, '{0, 4'hf, 8'h2b, 8'h00, 8'h00}};
  logic [7:0]  pat [4] = '{8'h4d, 8'hb2, 8'h17, 8'he8};  // Far-side bytes

  // ****************
  // Design and partner
  // ****************
  sdc_spi DUT (.clock(clock), .rst(rst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .sclk_i(sclk_w), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n_i));

  sdc_spi_slave_model u_slave (.active(act), .sclk(sclk_w), .mosi(mosi_w),
    .miso(p_miso), .cpol(p_cpol), .cpha(p_cpha), .lsb_first(p_lsb), .tx_byte(p_tx),
    .rx_byte(p_rx));

  // System clock, 10 ns
  always #5 clock = ~clock;

  // ****************
  // Tasks
  // ****************
  // Counts, verdict, end of run
  task stop_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // A wait ran out
  task fail();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    stop_test();
  endtask : fail

  // Byte compare
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle, held until ack, read data left in r
  task wb(input logic we, input logic [3:0] sel, input logic [7:0] idx, input logic [7:0] d);
    int i;
    wb_cyc   <= 1'h1;
    wb_stb   <= 1'h1;
    wb_we    <= we;
    wb_sel   <= sel;
    wb_adr   <= {idx, 2'h0};
    wb_dat_w <= {24'h0, d};
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end
    while (wb_ack !== 1'h1 && i < 20);
    if (wb_ack !== 1'h1)
      fail();
    r = wb_dat_r[7:0];
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clock);
  endtask : wb

  // Poll status until bit n is set
  task wait_cr(input int n);
    int i;
    i = 0;
    do
    begin
      wb(1'h0, 4'hf, 8'h2b, 8'h00);
      i++;
    end
    while (r[n] !== 1'h1 && i < 300);
    if (r[n] !== 1'h1)
      fail();
  endtask : wait_cr

  // Bench as mode 0 master on the slave role, 160 ns bit period
  task spi_mst(input logic [7:0] d);
    ss_n_i <= 1'h0;
    repeat (8) @(posedge clock);
    for (int i = 7; i >= 0; i--)
    begin
      tb_mosi <= d[i];
      repeat (8) @(posedge clock);
      q[i] = miso_w;
      tb_sclk <= 1'h1;
      repeat (8) @(posedge clock);
      tb_sclk <= 1'h0;
    end
    repeat (8) @(posedge clock);
    ss_n_i  <= 1'h1;
    tb_mosi <= ~d[0];
  endtask : spi_mst

  // ****************
  // Sequence
  // ****************
  initial
  begin
    {clock, wb_cyc, wb_stb, wb_we, tb_sclk, act, p_cpol, p_cpha, p_lsb} = 9'h0;
    {rst, ce, ss_n_i, tb_mosi} = 4'hf;
    {wb_adr, wb_sel, wb_dat_w} = 46'h0;
    p_tx = 8'ha5;
    n_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    // Register table cases
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].sel, rows[i].idx, rows[i].wd);
      if (!rows[i].we) chk(r, rows[i].exp);
    end
    // Master, second byte queued, first never read
    wb(1'h1, 4'hf, 8'h2c, 8'h60);
    wb(1'h1, 4'hf, 8'h2b, 8'h01);
    act <= 1'h1;
    wb(1'h1, 4'hf, 8'h29, 8'h3c);
    wb(1'h0, 4'hf, 8'h2b, 8'h00);
    chk(r, 8'h11);
    wb(1'h1, 4'hf, 8'h29, 8'hc3);
    wb(1'h0, 4'hf, 8'h2b, 8'h00);
    chk(r, 8'h01);
    wait_cr(6);
    chk(r, 8'h79);
    wb(1'h0, 4'hf, 8'h2b, 8'h00);
    chk(r, 8'h59);
    wb(1'h0, 4'hf, 8'h2a, 8'h00);
    chk(r, 8'ha5);
    chk(p_rx, 8'hc3);
    wb(1'h0, 4'hf, 8'h2b, 8'h00);
    chk(r, 8'h11);
    act <= 1'h0;
    wb(1'h1, 4'hf, 8'h2b, 8'h00);
    wb(1'h0, 4'hf, 8'h2b, 8'h00);
    chk(r, 8'h00);
    wb(1'h0, 4'hf, 8'h2a, 8'h00);
    chk(r, 8'ha5);
    // Every phase and polarity, least significant first where phase and polarity differ
    for (int m = 0; m < 4; m++)
    begin
      p_cpol <= m[0];
      p_cpha <= m[1];
      p_lsb  <= m[0] ^ m[1];
      p_tx   <= pat[m];
      wb(1'h1, 4'hf, 8'h2b, {m[0] ^ m[1], 4'h0, m[1], m[0], 1'h1});
      chk({7'h0, sclk_w}, {7'h0, m[0]});
      act <= 1'h1;
      wb(1'h1, 4'hf, 8'h29, ~pat[m]);
      wait_cr(3);
      wb(1'h0, 4'hf, 8'h2a, 8'h00);
      chk(r, pat[m]);
      chk(p_rx, ~pat[m]);
      act <= 1'h0;
      wb(1'h1, 4'hf, 8'h2b, 8'h00);
    end
    // Slave role, select from the pin
    wb(1'h1, 4'hf, 8'h2c, 8'h05);
    wb(1'h1, 4'hf, 8'h2b, 8'h01);
    wb(1'h1, 4'hf, 8'h29, 8'h96);
    chk({sclk_oe_n, miso_oe_n, miso_w, mosi_oe_n, 4'h0}, 8'hb0);
    spi_mst(8'h4b);
    chk(q, 8'h96);
    wb(1'h0, 4'hf, 8'h2b, 8'h00);
    chk(r, 8'h39);
    wb(1'h1, 4'hf, 8'h2a, 8'h00);
    wb(1'h0, 4'hf, 8'h2b, 8'h00);
    chk(r, 8'h11);
    wb(1'h0, 4'hf, 8'h2a, 8'h00);
    chk(r, 8'h4b);
    stop_test();
  end
endmodule : sdc_spi_tb
